// file: rtl/adcop_pkg.sv
package adcop_pkg;

	// Bus and sample widths, lane and clock tap counts, calibration counter width.
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 8;
	localparam int SAMPLE_W  = 12;
	localparam int LANES     = 6;
	localparam int CLK_TAPS  = 4;
	localparam int CAL_CNT_W = 16;

	// Calibration length in sample clock cycles.
	localparam int CAL_CYCLES = 1024;

	// Register offsets.
	localparam logic [7:0] OFS_PHASE_A = 8'h52;
	localparam logic [7:0] OFS_FORMAT  = 8'h62;
	localparam logic [7:0] OFS_PHASE_B = 8'h64;
	localparam logic [7:0] OFS_POL_A   = 8'h65;
	localparam logic [7:0] OFS_POL_B   = 8'h68;
	localparam logic [7:0] OFS_PHASE_C = 8'h6d;
	localparam logic [7:0] OFS_CONTROL = 8'h70;
	localparam logic [7:0] OFS_STATUS  = 8'h71;

	// Reset values.
	localparam logic [7:0] RST_PHASE_A = 8'h00;
	localparam logic [7:0] RST_FORMAT  = 8'h00;
	localparam logic [7:0] RST_PHASE_B = 8'h00;
	localparam logic [7:0] RST_POL_A   = 8'h00;
	localparam logic [7:0] RST_POL_B   = 8'h00;
	localparam logic [7:0] RST_PHASE_C = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;

	// Field positions.
	localparam int FMT_ORDER_LSB = 0;
	localparam int FMT_DDR_BIT   = 2;
	localparam logic [1:0] ORDER_EVEN_FIRST = 2'h0;
	localparam int PHA_TAP_LSB   = 0;
	localparam int PHA_INV_BIT   = 7;
	localparam int PHB_TAP_LSB   = 1;
	localparam int PHC_ALT_BIT   = 0;
	localparam int POLB_IND_BIT  = 6;
	localparam int POLB_CLK_BIT  = 7;
	localparam int CTL_SINGLE    = 0;
	localparam int CTL_IQ        = 1;
	localparam int CTL_STANDBY   = 2;
	localparam int CTL_SHUTDOWN  = 3;
	localparam int CTL_SOFT_RST  = 4;
	localparam int STS_CAL_DONE  = 0;
	localparam int STS_CAL_BUSY  = 1;
	localparam int STS_FOLLOWER  = 2;
	localparam int STS_DDR       = 3;

	// One converted sample with its side flags.
	typedef struct packed {
		logic [11:0] data;
		logic        first_ch;
		logic        overrange;
	} adcop_sample_type;

	// Output pins of the data port.
	typedef struct packed {
		logic [11:0] q;
		logic        ind_p;
		logic        ind_n;
		logic        clk_p;
		logic        clk_n;
	} adcop_link_type;

	// Calibration progress.
	typedef enum logic {
		CAL_BUSY_ST,
		CAL_DONE_ST
	} adcop_cal_type;

endpackage

// file: rtl/adcop_top.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Single-ended mode puts sample bits 0 to 11 on twelve separate outputs.
// - Double-data-rate mode carries two sample bits per differential pair, six pairs.
// - Even-first order sends even bits while data clock high, odd while low.
// - Output ordering field resets to even-bit-first.
// - Single-ended mode: marker on negative indicator leg, overrange on positive leg.
// - Double-data-rate: marker after clock rise, overrange after clock fall on indicator pair.
// - Overrange indicator is high while input beyond full scale, may lead data.
// - Marker rests low, high only for slots carrying first-channel data.
// - Single-channel operation keeps marker high unless in-phase/quadrature output.
// - Reset low holds reset; release loads register defaults and starts calibration.
// - Calibration-done goes high after first calibration, low again on restart.
// - Calibration-done is low in reset, holds its level in standby and shutdown unless a calibration restart drops it.
// - Upper serial device-address bit is zero, lower bit from select input.
// - Follower select high makes the sync pin an input, device follows.
// - Follower select low makes the device leader, driving the sync pin.
// - Data clock phase against data is adjustable through configuration registers.
// - Two configuration registers control output signal polarity.
// - Single-ended mode drives data clock on positive output only.
module adcop_top #(
	parameter int CAL_CYCLES = adcop_pkg::CAL_CYCLES
) (
	// Clock and reset.
	input  wire logic                     CLK,
	input  wire logic                     RST_N,
	// Register port.
	input  wire logic [7:0]               REG_ADDR,
	input  wire logic [7:0]               REG_WDATA,
	input  wire logic                     REG_WR,
	input  wire logic                     REG_RD,
	output var  logic [7:0]               REG_RDATA,
	// Converter core side.
	input  wire adcop_pkg::adcop_sample_type SAMPLE,
	output logic                          SAMPLE_TAKE,
	input  wire logic                     CAL_RESTART,
	// Data port pins.
	output var  adcop_pkg::adcop_link_type LINK,
	// Status and strap pins.
	output logic                          CAL_DONE,
	input  wire logic                     ADDR_SEL_LOW,
	input  wire logic                     CS_N,
	output logic [1:0]                    SERIAL_DEV_ADDR,
	// Synchronisation pins.
	input  wire logic                     FOLLOWER_SEL,
	input  wire logic                     SYNC_I,
	output var  logic                     SYNC_O,
	output logic                          SYNC_OE_N
);

	logic                         rst_meta_r;
	logic                         rst_n_r;
	logic [7:0]                   phase_a_r;
	logic [7:0]                   format_r;
	logic [7:0]                   phase_b_r;
	logic [7:0]                   pol_a_r;
	logic [7:0]                   pol_b_r;
	logic [7:0]                   phase_c_r;
	logic [7:0]                   control_r;
	logic                         soft_rst_r;
	logic [7:0]                   rd_nxt;
	logic [7:0]                   status;
	logic [1:0]                   adr_sync_r;
	logic [1:0]                   cs_sync_r;
	logic [1:0]                   fol_sync_r;
	logic [1:0]                   syn_sync_r;
	logic                         syn_prev_r;
	logic                         addr_lo_r;
	logic                         follower;
	logic                         sync_rise;
	adcop_pkg::adcop_cal_type     cal_state_r;
	logic [adcop_pkg::CAL_CNT_W-1:0] cal_cnt_r;
	logic                         ph_r;
	adcop_pkg::adcop_sample_type  samp_r;
	logic                         ddr_mode;
	logic                         odd_first;
	logic                         show_even;
	logic                         marker;
	logic [11:0]                  pol_bits;
	logic [11:0]                  q_nxt;
	logic                         ind_p_nxt;
	logic                         ind_n_nxt;
	logic [adcop_pkg::CLK_TAPS-1:0] cdl_r;
	logic [1:0]                   clk_tap;
	logic                         clk_sel;
	logic                         hold_cal;

	// Reset release passes two flip-flops; everything else uses the copy.
	// reset hold
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// Configuration registers take defaults in reset and software writes after.
	// register defaults
	always_ff @(posedge CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			phase_a_r <= adcop_pkg::RST_PHASE_A;
			format_r  <= adcop_pkg::RST_FORMAT;
			phase_b_r <= adcop_pkg::RST_PHASE_B;
			pol_a_r   <= adcop_pkg::RST_POL_A;
			pol_b_r   <= adcop_pkg::RST_POL_B;
			phase_c_r <= adcop_pkg::RST_PHASE_C;
			control_r <= adcop_pkg::RST_CONTROL;
		end
		else if (REG_WR)
		begin
			unique case (REG_ADDR)
				adcop_pkg::OFS_PHASE_A: phase_a_r <= REG_WDATA;
				adcop_pkg::OFS_FORMAT:  format_r  <= REG_WDATA;
				adcop_pkg::OFS_PHASE_B: phase_b_r <= REG_WDATA;
				adcop_pkg::OFS_POL_A:   pol_a_r   <= REG_WDATA;
				adcop_pkg::OFS_POL_B:   pol_b_r   <= REG_WDATA;
				adcop_pkg::OFS_PHASE_C: phase_c_r <= REG_WDATA;
				adcop_pkg::OFS_CONTROL: control_r <= REG_WDATA & ~(8'h01 << adcop_pkg::CTL_SOFT_RST);
				default:                control_r <= control_r;
			endcase
		end
	end

	// A write of one to the soft reset bit gives a single restart pulse.
	always_ff @(posedge CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			soft_rst_r <= 1'b0;
		else
			soft_rst_r <= REG_WR && (REG_ADDR == adcop_pkg::OFS_CONTROL) && REG_WDATA[adcop_pkg::CTL_SOFT_RST];
	end

	// Status word shows calibration, leader or follower and output mode.
	always_comb
	begin
		status                           = 8'h00;
		status[adcop_pkg::STS_CAL_DONE]  = (cal_state_r == adcop_pkg::CAL_DONE_ST);
		status[adcop_pkg::STS_CAL_BUSY]  = (cal_state_r == adcop_pkg::CAL_BUSY_ST);
		status[adcop_pkg::STS_FOLLOWER]  = follower;
		status[adcop_pkg::STS_DDR]       = ddr_mode;
	end

	// Read multiplexer; unmapped addresses read zero.
	always_comb
	begin
		unique case (REG_ADDR)
			adcop_pkg::OFS_PHASE_A: rd_nxt = phase_a_r;
			adcop_pkg::OFS_FORMAT:  rd_nxt = format_r;
			adcop_pkg::OFS_PHASE_B: rd_nxt = phase_b_r;
			adcop_pkg::OFS_POL_A:   rd_nxt = pol_a_r;
			adcop_pkg::OFS_POL_B:   rd_nxt = pol_b_r;
			adcop_pkg::OFS_PHASE_C: rd_nxt = phase_c_r;
			adcop_pkg::OFS_CONTROL: rd_nxt = control_r;
			adcop_pkg::OFS_STATUS:  rd_nxt = status;
			default:                rd_nxt = 8'h00;
		endcase
	end

	// Read data stand for exactly the cycle after the strobe.
	always_ff @(posedge CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			REG_RDATA <= 8'h00;
		else
			REG_RDATA <= REG_RD ? rd_nxt : 8'h00;
	end

	// Pin inputs pass two flip-flops before any logic reads them.
	always_ff @(posedge CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			adr_sync_r <= 2'h0;
			cs_sync_r  <= 2'h3;
			fol_sync_r <= 2'h0;
			syn_sync_r <= 2'h0;
			syn_prev_r <= 1'b0;
		end
		else
		begin
			adr_sync_r <= {adr_sync_r[0], ADDR_SEL_LOW};
			cs_sync_r  <= {cs_sync_r[0], CS_N};
			fol_sync_r <= {fol_sync_r[0], FOLLOWER_SEL};
			syn_sync_r <= {syn_sync_r[0], SYNC_I};
			syn_prev_r <= syn_sync_r[1];
		end
	end

	assign follower  = fol_sync_r[1];
	assign sync_rise = follower && syn_sync_r[1] && !syn_prev_r;

	// Address select is only followed while chip select is high.
	// stable while selected
	always_ff @(posedge CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			addr_lo_r <= 1'b0;
		else if (cs_sync_r[1])
			addr_lo_r <= adr_sync_r[1];
	end

	assign SERIAL_DEV_ADDR = {1'b0, addr_lo_r};

	// Calibration runs from reset release, restarts on request, freezes when idle.
	assign hold_cal = control_r[adcop_pkg::CTL_STANDBY] || control_r[adcop_pkg::CTL_SHUTDOWN];
	always_ff @(posedge CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			cal_state_r <= adcop_pkg::CAL_BUSY_ST;
			cal_cnt_r   <= '0;
		end
		else if (CAL_RESTART || soft_rst_r)
		begin
			cal_state_r <= adcop_pkg::CAL_BUSY_ST;
			cal_cnt_r   <= '0;
		end
		else if (!hold_cal)
		begin
			unique case (cal_state_r)
				adcop_pkg::CAL_BUSY_ST:
				begin
					if (cal_cnt_r == adcop_pkg::CAL_CNT_W'(CAL_CYCLES - 1))
						cal_state_r <= adcop_pkg::CAL_DONE_ST;
					else
						cal_cnt_r <= cal_cnt_r + 1'b1;
				end
				adcop_pkg::CAL_DONE_ST:
					cal_state_r <= adcop_pkg::CAL_DONE_ST;
			endcase
		end
	end

	assign CAL_DONE = (cal_state_r == adcop_pkg::CAL_DONE_ST);

	// Half-period phase of the data clock; a follower realigns on sync.
	// follow sync input
	always_ff @(posedge CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			ph_r <= 1'b1;
		else if (sync_rise)
			ph_r <= 1'b1;
		else
			ph_r <= ~ph_r;
	end

	// A new sample is taken at the end of each data clock period.
	assign SAMPLE_TAKE = ph_r;
	always_ff @(posedge CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			samp_r <= '0;
		else if (ph_r)
			samp_r <= SAMPLE;
	end

	// A leader drives a sync pulse when a first-channel sample is taken.
	// leader drives sync
	always_ff @(posedge CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			SYNC_O <= 1'b0;
		else
			SYNC_O <= !follower && ph_r && SAMPLE.first_ch;
	end

	assign SYNC_OE_N = follower;

	// Mode decode for the data port.
	// even first default
	assign odd_first = (format_r[adcop_pkg::FMT_ORDER_LSB +: 2] != adcop_pkg::ORDER_EVEN_FIRST);
	assign ddr_mode  = format_r[adcop_pkg::FMT_DDR_BIT];
	assign show_even = (ph_r == 1'b0) ^ odd_first;
	assign pol_bits  = {pol_b_r[5:0], pol_a_r[5:0]};

	// Marker for first-channel slots, or constant in single-channel operation.
	// first channel slots
	assign marker = control_r[adcop_pkg::CTL_SINGLE] ? !control_r[adcop_pkg::CTL_IQ] : samp_r.first_ch;

	// Each lane carries two sample bits in DDR, or its own two bits single-ended.
	for (genvar k = 0; k < adcop_pkg::LANES; k++)
	begin : g_lane
		logic lane_bit;
		assign lane_bit = (show_even ? samp_r.data[2*k] : samp_r.data[2*k+1]) ^ pol_a_r[k];
		assign q_nxt[2*k+1] = ddr_mode ? lane_bit : samp_r.data[2*k+1] ^ pol_bits[2*k+1];
		assign q_nxt[2*k]   = ddr_mode ? !lane_bit : samp_r.data[2*k] ^ pol_bits[2*k];
	end

	// Indicator pair: split legs single-ended, time-shared in DDR.
	always_comb
	begin
		if (ddr_mode)
		begin
			ind_p_nxt = ((ph_r == 1'b0) ? marker : samp_r.overrange) ^ pol_b_r[adcop_pkg::POLB_IND_BIT];
			ind_n_nxt = !ind_p_nxt;
		end
		else
		begin
			ind_p_nxt = samp_r.overrange ^ pol_b_r[adcop_pkg::POLB_IND_BIT];
			ind_n_nxt = marker ^ pol_b_r[adcop_pkg::POLB_IND_BIT];
		end
	end

	// Clock delay line gives selectable phase against the data bits.
	always_ff @(posedge CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			cdl_r <= '0;
		else
			cdl_r <= {cdl_r[adcop_pkg::CLK_TAPS-2:0], ph_r};
	end

	assign clk_tap = phase_c_r[adcop_pkg::PHC_ALT_BIT] ? phase_b_r[adcop_pkg::PHB_TAP_LSB +: 2] :
	                                                   phase_a_r[adcop_pkg::PHA_TAP_LSB +: 2];
	assign clk_sel = cdl_r[clk_tap] ^ phase_a_r[adcop_pkg::PHA_INV_BIT] ^ pol_b_r[adcop_pkg::POLB_CLK_BIT];

	// Output pins are registered so data and clock leave together.
	// receiver uses forwarded clock
	always_ff @(posedge CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			LINK <= '0;
		else
		begin
			LINK.q     <= q_nxt;
			LINK.ind_p <= ind_p_nxt;
			LINK.ind_n <= ind_n_nxt;
			LINK.clk_p <= clk_sel;
			LINK.clk_n <= ddr_mode ? !clk_sel : 1'b0;
		end
	end

endmodule

`default_nettype wire

// file: testbench/adcop_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module adcop_top_props #(
	parameter int CAL_CYCLES = adcop_pkg::CAL_CYCLES
) (
	// Clock and reset.
	input wire logic                      CLK,
	input wire logic                      RST_N,
	// Register port.
	input wire logic [7:0]                REG_ADDR,
	input wire logic [7:0]                REG_WDATA,
	input wire logic                      REG_WR,
	// Watched pins.
	input wire logic                      CAL_RESTART,
	input wire adcop_pkg::adcop_sample_type SAMPLE,
	input wire logic                      SAMPLE_TAKE,
	input wire logic                      SYNC_O,
	input wire adcop_pkg::adcop_link_type LINK,
	input wire logic                      CAL_DONE,
	input wire logic [1:0]                SERIAL_DEV_ADDR,
	input wire logic                      FOLLOWER_SEL,
	input wire logic                      SYNC_OE_N
);
	logic       ddr_r;
	logic       plain_r;
	logic [7:0] ctl_r;
	logic [2:0] age_r;
	logic       settle;
	logic       ctl_wr;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// Shadow of the mode registers, so the wire checks know the output format.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ddr_r <= 1'b0;
			plain_r <= 1'b1;
			ctl_r <= 8'h00;
		end
		else if (REG_WR)
		begin
			case (REG_ADDR)
				8'h52, 8'h64, 8'h65, 8'h68, 8'h6d: plain_r <= REG_WDATA == 8'h00;
				8'h62:
				begin
					ddr_r <= REG_WDATA[2];
					plain_r <= REG_WDATA[1:0] == 2'h0;
				end
				8'h70: ctl_r <= REG_WDATA & 8'h0f;
				default: ;
			endcase
		end
	end
	// Cycles since the last write, so outputs have time to follow a new mode.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			age_r <= 3'h0;
		else if (REG_WR)
			age_r <= 3'h0;
		else if (age_r != 3'h7)
			age_r <= age_r + 3'h1;
	end
	// Plain running leader with default phase and polarity.
	assign settle = age_r == 3'h7 && plain_r && ctl_r[3:2] == 2'h0 && !SYNC_OE_N;
	assign ctl_wr = REG_WR && REG_ADDR == 8'h70;
	a_se_clk_idle: assert property (settle && !ddr_r |-> LINK.clk_n == 1'b0)
		else $error("negative clock leg driven in single-ended mode");
	a_ddr_lane_pairs: assert property (settle && ddr_r |-> ((LINK.q ^ {LINK.q[10:0], 1'b0}) & 12'haaa) == 12'haaa)
		else $error("lane legs not complementary");
	a_ddr_ind_pair: assert property (settle && ddr_r |-> LINK.ind_n != LINK.ind_p)
		else $error("indicator legs not complementary");
	a_ddr_clk_pair: assert property (settle && ddr_r |-> LINK.clk_n != LINK.clk_p)
		else $error("clock legs not complementary");
	a_clk_half_toggle: assert property (settle |=> LINK.clk_p != $past(LINK.clk_p))
		else $error("forwarded clock did not toggle");
	a_cal_rst_low: assert property (disable iff (1'b0) !RST_N |-> !CAL_DONE)
		else $error("calibration flag high in reset");
	a_cal_restart_drop: assert property (CAL_RESTART |=> !CAL_DONE)
		else $error("calibration flag high after restart");
	a_cal_standby_hold: assert property (ctl_r[2] && !CAL_RESTART && !ctl_wr && !$past(ctl_wr) |=> $stable(CAL_DONE))
		else $error("calibration flag moved in standby");
	a_dev_addr_top: assert property (SERIAL_DEV_ADDR[1] == 1'b0)
		else $error("upper device address bit set");
	a_follow_input: assert property ($rose(FOLLOWER_SEL) |-> ##[1:4] SYNC_OE_N)
		else $error("sync pin still driven as follower");
	a_lead_output: assert property ($fell(FOLLOWER_SEL) |-> ##[1:4] !SYNC_OE_N)
		else $error("sync pin not driven as leader");
	a_lead_sync_pulse: assert property (!SYNC_OE_N && SAMPLE_TAKE && SAMPLE.first_ch |=> SYNC_O)
		else $error("leader gave no sync pulse on first channel");
	a_follow_sync_quiet: assert property (SYNC_OE_N |=> !SYNC_O)
		else $error("follower drove a sync pulse");
endmodule
bind adcop_top adcop_top_props #(.CAL_CYCLES(CAL_CYCLES)) u_props (.CLK(CLK), .RST_N(RST_N),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .CAL_RESTART(CAL_RESTART), .LINK(LINK),
	.SAMPLE(SAMPLE), .SAMPLE_TAKE(SAMPLE_TAKE), .SYNC_O(SYNC_O),
	.CAL_DONE(CAL_DONE), .SERIAL_DEV_ADDR(SERIAL_DEV_ADDR), .FOLLOWER_SEL(FOLLOWER_SEL), .SYNC_OE_N(SYNC_OE_N));
`default_nettype wire

// file: testbench/adcop_capture.sv
`timescale 1ns/10ps
`default_nettype none
module adcop_capture (
	// Clock and mode.
	input wire logic                      clk,
	input wire logic                      ddr,
	// Data port.
	input wire adcop_pkg::adcop_link_type link,
	// Rebuilt sample.
	output logic [11:0]                   word,
	output logic                          marker,
	output logic                          over
);
	logic        prev_clk;
	logic [11:0] first_q;
	logic        first_ind;
	logic [11:0] mix;
	// Even bits sit on the positive legs in the high half, odd bits in the low half.
	always_comb
	begin
		for (int k = 0; k < 6; k++)
		begin
			mix[2*k] = first_q[2*k+1];
			mix[2*k+1] = link.q[2*k+1];
		end
	end
	always_ff @(posedge clk)
	begin
		prev_clk <= link.clk_p;
		if (ddr && link.clk_p)
		begin
			first_q <= link.q;
			first_ind <= link.ind_p;
		end
		else if (ddr && prev_clk)
		begin
			word <= mix;
			marker <= first_ind;
			over <= link.ind_p;
		end
		else if (!ddr && link.clk_p && !prev_clk)
		begin
			word <= link.q;
			marker <= link.ind_n;
			over <= link.ind_p;
		end
	end
endmodule
`default_nettype wire

// file: testbench/adc_output_and_control_pins_test.sv
`timescale 1ns/10ps
`default_nettype none
module adc_output_and_control_pins_test;
	logic clk;
	logic rst_n;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	adcop_pkg::adcop_sample_type samp;
	adcop_pkg::adcop_link_type link;
	logic cal_restart;
	logic cal_done;
	logic adsel;
	logic cs_n;
	logic [1:0] dev_addr;
	logic fsel;
	logic sync_i;
	logic sync_oe_n;
	logic ddr_mode;
	logic [11:0] cap_word;
	logic cap_marker;
	logic cap_over;
	int error_cnt;
	int comparisons;
	int cyc = 0;
	logic [7:0] ofs [6] = '{8'h52, 8'h62, 8'h64, 8'h65, 8'h68, 8'h6d};
	// Rows: format, control, sample, expected word, marker, overrange.
	logic [43:0] rows [7] = '{
		{8'h00, 8'h00, 12'ha5c, 2'b10, 12'ha5c, 2'b10},
		{8'h00, 8'h00, 12'h3f0, 2'b01, 12'h3f0, 2'b01},
		{8'h00, 8'h01, 12'h123, 2'b00, 12'h123, 2'b10},
		{8'h00, 8'h03, 12'h123, 2'b10, 12'h123, 2'b00},
		{8'h04, 8'h00, 12'ha5c, 2'b10, 12'ha5c, 2'b10},
		{8'h04, 8'h00, 12'h5a3, 2'b01, 12'h5a3, 2'b01},
		{8'h04, 8'h01, 12'h0ff, 2'b01, 12'h0ff, 2'b11}};
	adcop_top #(.CAL_CYCLES(16)) dut (.CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SAMPLE(samp), .SAMPLE_TAKE(), .CAL_RESTART(cal_restart),
		.LINK(link), .CAL_DONE(cal_done), .ADDR_SEL_LOW(adsel), .CS_N(cs_n), .SERIAL_DEV_ADDR(dev_addr),
		.FOLLOWER_SEL(fsel), .SYNC_I(sync_i), .SYNC_O(), .SYNC_OE_N(sync_oe_n));
	adcop_capture far (.clk(clk), .ddr(ddr_mode), .link(link), .word(cap_word), .marker(cap_marker),
		.over(cap_over));
	// Sample clock.
	initial clk = 1'b0;
	always #5 clk = ~clk;
	// Prints the verdict and ends the run.
	task automatic conclude();
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Counts a comparison and reports a mismatch.
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Drives change at edges; peek lets the edge settle first.
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic peek(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One-cycle register write.
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// One-cycle register read, data checked in the following cycle.
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	// Cuts a hang short.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			error_cnt++;
			conclude();
		end
	end
	// Main sequence.
	initial
	begin
		rst_n = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		samp = '0;
		cal_restart = 1'b0;
		adsel = 1'b0;
		cs_n = 1'b1;
		fsel = 1'b0;
		sync_i = 1'b0;
		ddr_mode = 1'b0;
		error_cnt = 0;
		comparisons = 0;
		peek(19);
		chk(cal_done, 1'b0);
		step(1);
		rst_n <= 1'b1;
		peek(15);
		chk(cal_done, 1'b0);
		peek(10);
		chk(cal_done, 1'b1);
		reg_rd(8'h71, 8'h01);
		for (int i = 0; i < 6; i++)
		begin
			reg_rd(ofs[i], 8'h00);
			reg_wr(ofs[i], 8'h5a);
			reg_rd(ofs[i], 8'h5a);
			reg_wr(ofs[i], 8'h00);
		end
		reg_rd(8'h10, 8'h00);
		for (int i = 0; i < 7; i++)
		begin
			ddr_mode <= rows[i][38];
			reg_wr(8'h62, rows[i][43:36]);
			reg_wr(8'h70, rows[i][35:28]);
			samp <= rows[i][27:14];
			peek(10);
			chk(cap_word, rows[i][13:2]);
			chk(cap_marker, rows[i][1]);
			chk(cap_over, rows[i][0]);
		end
		// Low six outputs inverted in single-ended mode.
		ddr_mode <= 1'b0;
		reg_wr(8'h62, 8'h00);
		reg_wr(8'h65, 8'h3f);
		samp <= {12'ha5c, 2'b10};
		peek(10);
		chk(cap_word, 12'ha63);
		reg_wr(8'h65, 8'h00);
		reg_wr(8'h70, 8'h04);
		cal_restart <= 1'b1;
		step(1);
		cal_restart <= 1'b0;
		peek(30);
		chk(cal_done, 1'b0);
		reg_wr(8'h70, 8'h00);
		peek(30);
		chk(cal_done, 1'b1);
		reg_wr(8'h70, 8'h10);
		peek(2);
		chk(cal_done, 1'b0);
		peek(30);
		chk(cal_done, 1'b1);
		step(1);
		adsel <= 1'b1;
		peek(6);
		chk(dev_addr, 2'h1);
		step(1);
		cs_n <= 1'b0;
		fsel <= 1'b1;
		peek(6);
		chk(sync_oe_n, 1'b1);
		step(1);
		cs_n <= 1'b1;
		sync_i <= 1'b1;
		step(4);
		adsel <= 1'b0;
		sync_i <= 1'b0;
		fsel <= 1'b0;
		peek(6);
		chk(dev_addr, 2'h0);
		chk(sync_oe_n, 1'b0);
		conclude();
	end
endmodule
`default_nettype wire
